// >>> hdl/cws_pkg.sv
package cws_pkg;
  // Waveform word width and the length of the chained sequence of three words.
  localparam int unsigned CWS_WORD_W = 32;
  localparam int unsigned CWS_SEQ_W = 96;
  localparam int unsigned CWS_BURST_W = 4;
  localparam int unsigned CWS_CTRL_W = 4;

  // Avalon byte addresses of the registers.
  localparam logic [4:0] CWS_OFS_WORD0 = 5'h00;
  localparam logic [4:0] CWS_OFS_WORD1 = 5'h04;
  localparam logic [4:0] CWS_OFS_WORD2 = 5'h08;
  localparam logic [4:0] CWS_OFS_CTRL = 5'h0c;
  localparam logic [4:0] CWS_OFS_STAT = 5'h10;

  // Control register fields.
  localparam int unsigned CWS_CTL_HALF_RATE = 0;
  localparam int unsigned CWS_CTL_WIDTH16 = 1;
  localparam int unsigned CWS_CTL_PAIR_DIV2 = 2;
  localparam int unsigned CWS_CTL_ROM_DIV2 = 3;

  // Status register fields.
  localparam int unsigned CWS_STAT_BEATS_LSB = 0;
  localparam int unsigned CWS_STAT_BUSY = 8;

  // Reset values; the first word boots a single-word read with two divided cycles of delay.
  localparam logic [31:0] CWS_WORD0_RST = 32'h0000057f;
  localparam logic [31:0] CWS_WORD1_RST = 32'h00000000;
  localparam logic [31:0] CWS_WORD2_RST = 32'h00000000;
  localparam logic [3:0] CWS_CTRL_RST = 4'hc;

  // Kind of memory served by one access.
  typedef enum logic [1:0] {
    CWS_KIND_ADRAM,
    CWS_KIND_SDRAM,
    CWS_KIND_SYNC_MASK_ROM
  } cws_kind_t;
endpackage : cws_pkg

// >>> hdl/cws_rot_if.sv
interface cws_rot_if #(
  parameter int unsigned SEQ_W = 96
);
  logic load;
  logic [SEQ_W-1:0] load_val;
  logic step;
  logic cur_bit;
  logic next_bit;

  modport ctl (output load, output load_val, output step, input cur_bit, input next_bit);
  modport rot (input load, input load_val, input step, output cur_bit, output next_bit);
endinterface : cws_rot_if

// >>> hdl/cws_rotator.sv
module cws_rotator #(
  parameter int unsigned SEQ_W = cws_pkg::CWS_SEQ_W
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  cws_rot_if.rot rot_if
);
  import cws_pkg::*;

  typedef struct packed {
    logic [SEQ_W-1:0] bits;
  } cws_rot_state_t;

  cws_rot_state_t q;
  cws_rot_state_t d;

  // Refuse a sequence too short to have a current and a next bit.
  if (SEQ_W < 2) begin : g_bad_len
    $error("Sequence length below two bits.");
  end

  // Load takes priority; a step rotates so the spent low bit wraps to the top.
  always_comb begin
    d = q;
    if (rot_if.load) begin
      d.bits = rot_if.load_val;
    end else if (rot_if.step) begin
      d.bits = {q.bits[0], q.bits[SEQ_W-1:1]};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // The current bit is the one on the strobe now; the next one is for edge lookahead.
  assign rot_if.cur_bit = q.bits[0];
  assign rot_if.next_bit = q.bits[1];

  property p_rot_wrap;
    @(posedge clk_sys_in) disable iff (srst_in)
    (rot_if.step && !rot_if.load) |=> (q.bits[SEQ_W-1] == $past(q.bits[0]));
  endproperty
  a_rot_wrap: assert property (p_rot_wrap) else $error("Rotated bit did not wrap to top.");
endmodule : cws_rotator

// >>> hdl/cws_cas_sequencer.sv
// Functional notes
// - Async DRAM: word0 bit 0 drives the column strobe as row strobe asserts.
// - The three words form one continuous 96-bit sequence, word0 first.
// - Bit 1 deasserts the column strobe and mask, bit 0 asserts them.
// - Count column pulses; row strobe deasserts the cycle after the last pulse ends.
// - Sequence rotates; bit 0 of word0 wraps to the top bit of word2.
// - Sync memories: column strobe asserts at first 1-to-0; bit 0 one cycle late.
// - SDRAM: column strobe stays asserted for the whole burst once asserted.
// - Sync ROM: column strobe asserted only during the first column address.
// - Each 0-to-1 after column assertion is a data-latch reference edge.
// - The two-zero extra latch delay is honoured only when divide-by-two is clear.
// - With divide-by-two set, odd-numbered 0-to-1 transitions are ignored.
// - Low byte 0111 then 0101 fill: sync delay 4 cycles, async 3 or 6.
// - 1010 fill at full clock latches at 3 cycles, at divided clock 4.
// - Seven leading ones: sync delay 8 cycles, async 7 or 14.
// - For sync memories each bit lasts one CPU cycle regardless of divisor.
// - Async DRAM bit lasts one cycle, or two at half rate or 16-bit width.
//
// Added by the designer: the address map and register access over Avalon-MM.
module cws_cas_sequencer #(
  parameter int unsigned BURST_W = cws_pkg::CWS_BURST_W
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic access_req_in,
  input wire cws_pkg::cws_kind_t access_kind_in,
  input wire logic [BURST_W-1:0] burst_len_in,
  output logic access_busy_out,
  output logic row_strobe_n_out,
  output logic col_strobe_mask_n_out,
  output logic sync_col_strobe_n_out,
  output logic data_latch_ref_out
);
  import cws_pkg::*;

  typedef enum logic [1:0] {
    CWS_ST_IDLE,
    CWS_ST_RUN,
    CWS_ST_FINAL
  } cws_state_t;

  typedef struct packed {
    cws_state_t st;
    logic ack;
    logic [31:0] rdata;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [CWS_CTRL_W-1:0] ctrl;
    cws_kind_t kind;
    logic [BURST_W-1:0] burst;
    logic [BURST_W-1:0] beats;
    logic ph;
    logic row_n;
    logic sb;
    logic pb;
    logic sb_ok;
    logic cas_seen;
    logic [1:0] zc;
    logic fr;
    logic par;
    logic two_zero;
    logic pend;
    logic ref_p;
  } cws_seq_state_t;

  cws_seq_state_t q;
  cws_seq_state_t d;

  cws_rot_if #(.SEQ_W(CWS_SEQ_W)) rot_if ();

  cws_rotator #(.SEQ_W(CWS_SEQ_W)) u_rot (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .rot_if(rot_if)
  );

  // The beat counter and status field must fit one byte and count at least eight beats.
  if (BURST_W < 4 || BURST_W > 8) begin : g_bad_burst
    $error("Burst counter width must lie between 4 and 8.");
  end

  // Byte-lane merge for writes carrying partial byte enables.
  function automatic logic [31:0] cws_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : cws_merge

  logic bus_req;
  logic slow;
  logic div2;
  logic is_async;
  logic sync_run;
  logic fall_now;
  logic rise_now;
  logic counted;
  logic tz_now;
  logic late;
  // Lookahead strobe for a counted two-zero rise at divided clock.
  logic early;
  logic last_beat;

  // Decoded conditions shared by the next-state logic and the strobe outputs.
  always_comb begin
    bus_req = avs_read_in | avs_write_in;
    slow = q.ctrl[CWS_CTL_HALF_RATE] | q.ctrl[CWS_CTL_WIDTH16];
    div2 = (q.kind == CWS_KIND_SYNC_MASK_ROM) ? q.ctrl[CWS_CTL_ROM_DIV2] : q.ctrl[CWS_CTL_PAIR_DIV2];
    is_async = (q.kind == CWS_KIND_ADRAM);
    sync_run = (q.st != CWS_ST_IDLE) && !is_async;
    fall_now = sync_run && q.sb_ok && q.pb && !q.sb && !q.cas_seen;
    rise_now = sync_run && q.sb_ok && !q.pb && q.sb && q.cas_seen;
    counted = rise_now && (!div2 || q.par);
    tz_now = q.fr ? q.two_zero : (q.zc == 2'h2);
    // At divided clock the two-zero pattern is served a cycle early, which drops its extra
    // latching cycle; the registered reference pulse then lands on the rise itself.
    late = div2 && q.fr && q.two_zero;
    early = late && sync_run && q.sb_ok && q.cas_seen && q.par && !q.sb && rot_if.cur_bit;
    last_beat = (q.beats + 1'b1) == q.burst;
  end

  // One answer per request after a single wait cycle; reads are prepared in that cycle.
  always_comb begin
    d = q;
    d.ref_p = 1'b0;
    rot_if.load = 1'b0;
    rot_if.load_val = {q.w2, q.w1, q.w0};
    rot_if.step = 1'b0;
    d.ack = bus_req && !q.ack;
    if (bus_req && !q.ack) begin
      case (avs_address_in)
        CWS_OFS_WORD0: d.rdata = q.w0;
        CWS_OFS_WORD1: d.rdata = q.w1;
        CWS_OFS_WORD2: d.rdata = q.w2;
        CWS_OFS_CTRL: d.rdata = {{(32 - CWS_CTRL_W){1'b0}}, q.ctrl};
        CWS_OFS_STAT: begin
          d.rdata = '0;
          d.rdata[CWS_STAT_BUSY] = (q.st != CWS_ST_IDLE);
          d.rdata[CWS_STAT_BEATS_LSB +: BURST_W] = q.beats;
        end
        default: d.rdata = '0;
      endcase
    end
    // Writes land on the edge where waitrequest is low; unmapped writes are dropped.
    if (avs_write_in && q.ack) begin
      case (avs_address_in)
        CWS_OFS_WORD0: d.w0 = cws_merge(q.w0, avs_writedata_in, avs_byteenable_in);
        CWS_OFS_WORD1: d.w1 = cws_merge(q.w1, avs_writedata_in, avs_byteenable_in);
        CWS_OFS_WORD2: d.w2 = cws_merge(q.w2, avs_writedata_in, avs_byteenable_in);
        CWS_OFS_CTRL: begin
          if (avs_byteenable_in[0]) begin
            d.ctrl = avs_writedata_in[CWS_CTRL_W-1:0];
          end
        end
        default: d.ctrl = q.ctrl;
      endcase
    end
    // Access sequencing; word writes during an access only affect the next one.
    case (q.st)
      CWS_ST_IDLE: begin
        if (access_req_in && (burst_len_in != '0)) begin
          rot_if.load = 1'b1;
          d.st = CWS_ST_RUN;
          d.row_n = 1'b0;
          d.kind = access_kind_in;
          d.burst = burst_len_in;
          d.beats = '0;
          d.ph = 1'b0;
          d.sb = 1'b1;
          d.pb = 1'b1;
          d.sb_ok = 1'b0;
          d.cas_seen = 1'b0;
          d.zc = 2'h0;
          d.fr = 1'b0;
          d.par = 1'b0;
          d.two_zero = 1'b0;
          d.pend = 1'b0;
        end
      end
      CWS_ST_RUN: begin
        if (is_async) begin
          // A bit lasts two cycles at half rate or 16-bit width.
          rot_if.step = !slow || q.ph;
          d.ph = slow && !q.ph;
          if (rot_if.step && !rot_if.cur_bit && rot_if.next_bit) begin
            if (last_beat) begin
              d.st = CWS_ST_FINAL;
            end else begin
              d.beats = BURST_W'(q.beats + 1'b1);
            end
          end
        end else begin
          // The sync view trails the rotator by one cycle, one bit per cycle.
          rot_if.step = 1'b1;
          d.sb = rot_if.cur_bit;
          d.pb = q.sb;
          d.sb_ok = 1'b1;
          if (fall_now) begin
            d.cas_seen = 1'b1;
            d.zc = 2'h1;
          end else if (q.cas_seen && !q.fr && !q.sb) begin
            d.zc = 2'h2;
          end
          if (rise_now) begin
            d.fr = 1'b1;
            d.par = !q.par;
            d.two_zero = tz_now;
          end
          // Divided clock serves the two-zero pattern one cycle early so both patterns match;
          // pend marks that the pulse now out was taken ahead of its rise.
          d.pend = early;
          if ((counted && !late) || early) begin
            d.ref_p = 1'b1;
            d.beats = BURST_W'(q.beats + 1'b1);
            if (last_beat) begin
              d.st = CWS_ST_FINAL;
            end
          end
        end
      end
      CWS_ST_FINAL: begin
        d.st = CWS_ST_IDLE;
        d.row_n = 1'b1;
        d.cas_seen = 1'b0;
        d.pend = 1'b0;
      end
      default: begin
        d.st = CWS_ST_IDLE;
        d.row_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      q <= '0;
      q.st <= CWS_ST_IDLE;
      q.w0 <= CWS_WORD0_RST;
      q.w1 <= CWS_WORD1_RST;
      q.w2 <= CWS_WORD2_RST;
      q.ctrl <= CWS_CTRL_RST;
      q.kind <= CWS_KIND_ADRAM;
      q.row_n <= 1'b1;
      q.sb <= 1'b1;
      q.pb <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Strobe outputs gate registered state; a 1 bit holds the async strobe high.
  always_comb begin
    avs_readdata_out = q.rdata;
    avs_waitrequest_out = bus_req && !q.ack;
    access_busy_out = (q.st != CWS_ST_IDLE);
    row_strobe_n_out = q.row_n;
    data_latch_ref_out = q.ref_p;
    col_strobe_mask_n_out = ((q.st != CWS_ST_IDLE) && is_async) ? rot_if.cur_bit : 1'b1;
    sync_col_strobe_n_out = !(fall_now ||
                              (sync_run && q.cas_seen && (q.kind == CWS_KIND_SDRAM)));
  end

  property p_restart;
    @(posedge clk_sys_in) disable iff (srst_in)
    (q.st == CWS_ST_IDLE && access_req_in && burst_len_in != '0)
      |=> (!row_strobe_n_out && rot_if.cur_bit == $past(q.w0[0]));
  endproperty
  a_restart: assert property (p_restart) else $error("Access did not restart at bit 0.");

  property p_bit0_async;
    @(posedge clk_sys_in) disable iff (srst_in)
    ($fell(row_strobe_n_out) && q.kind == CWS_KIND_ADRAM)
      |-> (col_strobe_mask_n_out == $past(q.w0[0]));
  endproperty
  a_bit0_async: assert property (p_bit0_async) else $error("Bit 0 not on strobe with row.");

  property p_half_hold;
    @(posedge clk_sys_in) disable iff (srst_in)
    (q.st == CWS_ST_RUN && q.kind == CWS_KIND_ADRAM && slow && !q.ph)
      |=> $stable(col_strobe_mask_n_out);
  endproperty
  a_half_hold: assert property (p_half_hold) else $error("Half-rate bit lasted one cycle.");

  property p_row_close;
    @(posedge clk_sys_in) disable iff (srst_in)
    (q.st == CWS_ST_FINAL && q.kind == CWS_KIND_ADRAM)
      |-> col_strobe_mask_n_out && !row_strobe_n_out ##1 row_strobe_n_out;
  endproperty
  a_row_close: assert property (p_row_close) else $error("Row strobe closed at wrong cycle.");

  property p_sync_fall;
    @(posedge clk_sys_in) disable iff (srst_in)
    $fell(sync_col_strobe_n_out) |-> (!q.sb && q.pb && q.kind != CWS_KIND_ADRAM);
  endproperty
  a_sync_fall: assert property (p_sync_fall) else $error("Sync strobe fell off a 1-to-0.");

  property p_sdram_hold;
    @(posedge clk_sys_in) disable iff (srst_in)
    (!sync_col_strobe_n_out && q.kind == CWS_KIND_SDRAM && q.st == CWS_ST_RUN)
      |=> !sync_col_strobe_n_out;
  endproperty
  a_sdram_hold: assert property (p_sdram_hold) else $error("SDRAM strobe released early.");

  property p_rom_once;
    @(posedge clk_sys_in) disable iff (srst_in)
    (!sync_col_strobe_n_out && q.kind == CWS_KIND_SYNC_MASK_ROM) |=> sync_col_strobe_n_out [*2];
  endproperty
  a_rom_once: assert property (p_rom_once) else $error("ROM strobe held past first column.");

  property p_ref_cause;
    @(posedge clk_sys_in) disable iff (srst_in)
    data_latch_ref_out |-> ((q.pend && rise_now) || $past(rise_now));
  endproperty
  a_ref_cause: assert property (p_ref_cause) else $error("Latch reference without a rise.");

  property p_odd_skip;
    @(posedge clk_sys_in) disable iff (srst_in)
    (rise_now && !q.fr && div2) |=> !data_latch_ref_out ##1 (data_latch_ref_out == q.two_zero);
  endproperty
  a_odd_skip: assert property (p_odd_skip) else $error("First rise used at divided clock.");

  property p_div2_late;
    @(posedge clk_sys_in) disable iff (srst_in)
    (rise_now && q.fr && q.par && div2) |-> (data_latch_ref_out == q.two_zero);
  endproperty
  a_div2_late: assert property (p_div2_late) else $error("Divided latch edge kept extra delay.");

  c_async_done: cover property (@(posedge clk_sys_in) disable iff (srst_in)
    (q.st == CWS_ST_FINAL && q.kind == CWS_KIND_ADRAM));
  c_sdram_done: cover property (@(posedge clk_sys_in) disable iff (srst_in)
    (q.st == CWS_ST_FINAL && q.kind == CWS_KIND_SDRAM));
  c_rom_ref: cover property (@(posedge clk_sys_in) disable iff (srst_in)
    (data_latch_ref_out && q.kind == CWS_KIND_SYNC_MASK_ROM && div2));
endmodule : cws_cas_sequencer

// >>> verif/cws_mem_model.sv
// Passive model of the memory devices: it measures the strobe timing of each access in CPU cycles.
module cws_mem_model (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic row_strobe_n_in,
  input wire logic col_strobe_mask_n_in,
  input wire logic sync_col_strobe_n_in,
  input wire logic data_latch_ref_in,
  output logic [55:0] meas_out,
  output logic done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int t;
  int t_col;
  int t_rise;
  int t_sfall;
  int t_ref;
  int pulses;
  int refs;
  int slen;
  logic in_row = 1'b0;
  logic col_prev;

  // Every sample while the row strobe is low is one cycle; a device cannot see finer detail.
  always @(posedge clk_sys_in) begin
    done_out <= 1'b0;
    if (srst_in) begin
      in_row = 1'b0;
    end else if (row_strobe_n_in === 1'b0) begin
      if (!in_row) begin
        t = 0;
        t_col = -1;
        t_rise = -1;
        t_sfall = -1;
        t_ref = -1;
        pulses = 0;
        refs = 0;
        slen = 0;
        col_prev = 1'b1;
        in_row = 1'b1;
      end
      if (col_prev && !col_strobe_mask_n_in) pulses++;
      if (!col_prev && col_strobe_mask_n_in) t_rise = t;
      if ((!col_strobe_mask_n_in || !sync_col_strobe_n_in) && t_col < 0) t_col = t;
      if (!sync_col_strobe_n_in) begin
        slen++;
        if (t_sfall < 0) t_sfall = t;
      end
      if (data_latch_ref_in) begin
        refs++;
        if (t_ref < 0) t_ref = t;
      end
      col_prev = col_strobe_mask_n_in;
      t++;
    end else if (in_row) begin
      // Row strobe released: hand over one record of the access just seen.
      meas_out <= {8'(t_col), 8'(pulses), 8'(t - t_rise), 8'(t), 8'(t_ref - t_sfall), 8'(refs),
                   8'(slen)};
      done_out <= 1'b1;
      in_row = 1'b0;
    end
  end
endmodule : cws_mem_model

// >>> verif/cws_cas_sequencer_tb.sv
module cws_cas_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cws_pkg::*;
  localparam int X = -1;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic access_req = 1'b0;
  cws_kind_t access_kind = CWS_KIND_ADRAM;
  logic [CWS_BURST_W-1:0] burst_len = 4'h1;
  logic busy;
  logic row_n;
  logic col_n;
  logic sync_n;
  logic ref_pulse;
  logic [55:0] meas;
  logic [55:0] exp_meas;
  logic done;
  logic [31:0] rnd;
  logic [3:0] n;
  int miscompares = 0;
  int num_checks = 0;
  logic [31:0] rd_q[$];
  logic [55:0] acc_q[$];
  string names[7] = '{"slen", "refs", "tac", "len", "gap", "pulses", "trcd"};

  cws_cas_sequencer dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .avs_address_in(avs_address),
    .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
    .avs_byteenable_in(avs_byteenable), .avs_readdata_out(avs_readdata),
    .avs_waitrequest_out(avs_waitrequest), .access_req_in(access_req),
    .access_kind_in(access_kind), .burst_len_in(burst_len), .access_busy_out(busy),
    .row_strobe_n_out(row_n), .col_strobe_mask_n_out(col_n), .sync_col_strobe_n_out(sync_n),
    .data_latch_ref_out(ref_pulse));

  cws_mem_model mem (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .row_strobe_n_in(row_n),
    .col_strobe_mask_n_in(col_n), .sync_col_strobe_n_in(sync_n), .data_latch_ref_in(ref_pulse),
    .meas_out(meas), .done_out(done));

  // Free-running system clock.
  initial begin
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] expv);
    num_checks++;
    if (seen !== expv) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, expv, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // One bus cycle; the request stands until the rising edge at which waitrequest is low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clk_sys_in);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys_in);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] expv);
    rd_q.push_back(expv);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask : rd

  task automatic prog(input logic [31:0] w0, input logic [31:0] fill, input logic [3:0] c);
    bus(1'b1, CWS_OFS_WORD0, w0, 4'hf);
    bus(1'b1, CWS_OFS_WORD1, fill, 4'hf);
    bus(1'b1, CWS_OFS_WORD2, fill, 4'hf);
    bus(1'b1, CWS_OFS_CTRL, {28'h0, c}, 4'hf);
  endtask : prog

  // One access; the expected record is noted before the request goes out.
  task automatic acc(input cws_kind_t k, input logic [3:0] bl, input logic [55:0] e);
    int i;
    acc_q.push_back(e);
    @(posedge clk_sys_in);
    access_req <= 1'b1;
    access_kind <= k;
    burst_len <= bl;
    @(posedge clk_sys_in);
    access_req <= 1'b0;
    i = 0;
    do begin
      @(negedge clk_sys_in);
      i++;
    end while (!(busy === 1'b0 && row_n === 1'b1) && i < 400);
    if (i >= 400) miscompares++;
    @(posedge clk_sys_in);
  endtask : acc

  function automatic logic [55:0] m(int trcd, int pl, int gap, int len, int tac, int refs,
                                   int slen);
    return {8'(trcd), 8'(pl), 8'(gap), 8'(len), 8'(tac), 8'(refs), 8'(slen)};
  endfunction : m

  // Watcher: takes the oldest note whenever read data or an access record appears.
  always @(negedge clk_sys_in) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      check("readdata", avs_readdata, rd_q.pop_front());
    end
    if (done === 1'b1) begin
      exp_meas = acc_q.pop_front();
      check("busy", 32'(busy), 32'h0);
      for (int i = 0; i < 7; i++) begin
        if (exp_meas[8*i +: 8] !== 8'hff) begin
          check(names[i], 32'(meas[8*i +: 8]), 32'(exp_meas[8*i +: 8]));
        end
      end
    end
  end

  // Watchdog sized well above the several hundred cycles the sequence needs.
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    miscompares++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'hc32243c8));
    repeat (3) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    rd(CWS_OFS_WORD0, CWS_WORD0_RST);
    rd(CWS_OFS_WORD1, CWS_WORD1_RST);
    rd(CWS_OFS_WORD2, CWS_WORD2_RST);
    rd(CWS_OFS_STAT, 32'h0);
    rd(CWS_OFS_CTRL, {28'h0, CWS_CTRL_RST});
    bus(1'b1, 5'h14, 32'hffffffff, 4'hf);
    rd(5'h14, 32'h0);
    bus(1'b1, CWS_OFS_CTRL, 32'h0, 4'h0);
    rd(CWS_OFS_CTRL, {28'h0, CWS_CTRL_RST});
    rnd = $urandom;
    bus(1'b1, CWS_OFS_WORD1, rnd, 4'hf);
    rd(CWS_OFS_WORD1, rnd);
    // Async: two-clock phases at full rate, one-bit phases otherwise, random burst lengths.
    for (int c = 0; c < 4; c++) begin
      n = 4'(1 + $urandom % 8);
      if (c == 0) prog(32'h3333333f, 32'h33333333, 4'(c));
      else prog(32'h55555557, 32'h55555555, 4'(c));
      acc(CWS_KIND_ADRAM, n, m(6, n, 1, X, X, X, X));
    end
    for (int c = 0; c < 2; c++) begin
      prog(32'h0000017f, 32'h0, 4'(c));
      acc(CWS_KIND_ADRAM, 4'h1, m(7 * (c + 1), 1, 1, X, X, X, X));
    end
    prog(32'haaaaaaa7, 32'haaaaaaaa, 4'h0);
    acc(CWS_KIND_ADRAM, 4'h1, m(3, 1, 1, 6, X, X, X));
    bus(1'b1, CWS_OFS_CTRL, 32'h1, 4'hf);
    acc(CWS_KIND_ADRAM, 4'h1, m(6, 1, 1, X, X, X, X));
    // Only word0 holds a pulse: the second beat needs the sequence to wrap around.
    prog(32'hffffffe7, 32'hffffffff, 4'h0);
    acc(CWS_KIND_ADRAM, 4'h2, m(3, 2, 1, 102, X, X, X));
    // Sync memories: both fill patterns at full and divided memory clock.
    for (int p = 0; p < 2; p++) begin
      for (int d = 0; d < 2; d++) begin
        if (p == 1) prog(32'haaaaaaa7, 32'haaaaaaaa, d ? 4'h4 : 4'h0);
        else prog(32'h55555557, 32'h55555555, d ? 4'h4 : 4'h0);
        acc(CWS_KIND_SDRAM, 4'h1, m(4, 0, X, X, d ? 4 : 2 + p, 1,
                                    (p == 0 && d == 0) ? 3 : X));
      end
    end
    prog(32'h5555557f, 32'h55555555, 4'h0);
    acc(CWS_KIND_SDRAM, 4'h1, m(8, 0, X, X, X, 1, X));
    bus(1'b1, CWS_OFS_CTRL, 32'h4, 4'hf);
    acc(CWS_KIND_SDRAM, 4'h1, m(8, 0, X, X, X, 1, X));
    for (int d = 0; d < 2; d++) begin
      n = 4'(1 + $urandom % 8);
      prog(32'h55555557, 32'h55555555, d ? 4'h4 : 4'h0);
      acc(CWS_KIND_SDRAM, n, m(4, 0, X, X, X, n, X));
    end
    // Shared words between SDRAM and ROM, same delay; ROM ignores the half-rate select.
    prog(32'h55555557, 32'h55555555, 4'h9);
    acc(CWS_KIND_SYNC_MASK_ROM, 4'h1, m(4, 0, X, X, 4, 1, 1));
    bus(1'b1, CWS_OFS_CTRL, 32'h1, 4'hf);
    acc(CWS_KIND_SYNC_MASK_ROM, 4'h1, m(4, 0, X, X, 2, 1, 1));
    acc(CWS_KIND_SYNC_MASK_ROM, 4'h1, m(4, 0, X, X, 2, 1, 1));
    repeat (4) @(posedge clk_sys_in);
    report_and_stop();
  end
endmodule : cws_cas_sequencer_tb
